// >>> core/fcs_pkg.sv
// Shared constants and types for the flash command and status controller.
package fcs_pkg;
    localparam int CLK_NS       = 5;
    localparam int FA_W         = 18;
    localparam int FD_W         = 8;
    // Bus cycle timing on the flash pins.
    localparam int T_SETUP_NS   = 10;
    localparam int T_WP_NS      = 45;
    localparam int T_ACC_NS     = 150;
    localparam int T_HOLD_NS    = 10;
    localparam int T_REC_NS     = 20;
    localparam int SYNC_CYC     = 3;
    localparam int T_SETUP_CYC  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int T_HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_REC_CYC    = (T_REC_NS + CLK_NS - 1) / CLK_NS;
    // Longest pause allowed between two cycles of one command sequence.
    localparam int GAP_LIMIT_US = 50;
    localparam int GAP_LIMIT_CYC = GAP_LIMIT_US * 1000 / CLK_NS;
    // Unlock pattern and command codes.
    localparam logic [FA_W-1:0] UNLOCK_A1 = 18'h00555;
    localparam logic [FA_W-1:0] UNLOCK_A2 = 18'h002aa;
    localparam logic [FA_W-1:0] ADDR_ANY  = 18'h00000;
    localparam logic [FD_W-1:0] UNLOCK_D1        = 8'haa;
    localparam logic [FD_W-1:0] UNLOCK_D2        = 8'h55;
    localparam logic [FD_W-1:0] CMD_AUTOSEL      = 8'h90;
    localparam logic [FD_W-1:0] CMD_PROGRAM      = 8'ha0;
    localparam logic [FD_W-1:0] CMD_ERASE_SETUP  = 8'h80;
    localparam logic [FD_W-1:0] CMD_CHIP_ERASE   = 8'h10;
    localparam logic [FD_W-1:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [FD_W-1:0] CMD_SUSPEND      = 8'hb0;
    localparam logic [FD_W-1:0] CMD_RESUME       = 8'h30;
    localparam logic [FD_W-1:0] CMD_RESET        = 8'hf0;
    localparam int POLL_BIT = 7;
    localparam int FAIL_BIT = 5;
    // Register offsets, status fields and reset values.
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_ADDR   = 12'h004;
    localparam logic [11:0] REG_WDATA  = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam logic [11:0] REG_RDATA  = 12'h010;
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_FAIL    = 2;
    localparam int ST_REFUSED = 3;
    localparam logic [FA_W-1:0] ADDR_RST  = 18'h00000;
    localparam logic [FD_W-1:0] WDATA_RST = 8'hff;

    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_PROGRAM = 4'h3,
        OP_CHIP_ERASE = 4'h4, OP_SECTOR_ERASE = 4'h5, OP_SECTOR_ADD = 4'h6,
        OP_SUSPEND = 4'h7, OP_RESUME = 4'h8, OP_POLL = 4'h9
    } fcs_op_t;

    typedef struct packed {
        logic            write;
        logic [FA_W-1:0] addr;
        logic [FD_W-1:0] data;
    } fcs_cyc_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fcs_strobe_t;

    localparam fcs_strobe_t STROBE_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage : fcs_pkg

// >>> core/fcs_sync.sv
// Three-stage synchroniser that passes a word once two stages agree.
`timescale 1ns/1ps
module fcs_sync
    import fcs_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule : fcs_sync

// >>> core/fcs_cycle.sv
// One read or write bus cycle on the flash pins.
`timescale 1ns/1ps
module fcs_cycle
    import fcs_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            start,
    input  wire fcs_cyc_t        req,
    input  wire logic [FD_W-1:0] dq_in,
    output fcs_strobe_t          strobe,
    output logic      [FA_W-1:0] addr,
    output logic      [FD_W-1:0] dq_out,
    output logic                 dq_oe,
    output logic                 idle,
    output logic                 done,
    output logic      [FD_W-1:0] rdata
);
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000, PH_SETUP = 3'b001, PH_STROBE = 3'b010,
        PH_HOLD = 3'b011, PH_REC = 3'b100
    } fcs_phase_t;

    fcs_phase_t phase;
    logic [7:0] cnt;
    logic       is_wr;
    wire        cnt_zero = (cnt == 8'h00);

    assign idle = (phase == PH_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Address is set up before the strobe falls and data stays driven through
    // the hold, so the flash latches both cleanly.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase  <= PH_IDLE;
            cnt    <= 8'h00;
            is_wr  <= 1'b0;
            strobe <= STROBE_IDLE;
            addr   <= ADDR_ANY;
            dq_out <= 8'h00;
            dq_oe  <= 1'b0;
            done   <= 1'b0;
            rdata  <= 8'h00;
        end else begin
            done <= 1'b0;
            case (phase)
                PH_IDLE: if (start) begin
                    phase       <= PH_SETUP;
                    cnt         <= 8'(T_SETUP_CYC - 1);
                    is_wr       <= req.write;
                    addr        <= req.addr;
                    dq_out      <= req.data;
                    dq_oe       <= req.write;
                    strobe.ce_n <= 1'b0;
                end
                PH_SETUP: if (cnt_zero) begin
                    phase       <= PH_STROBE;
                    cnt         <= is_wr ? 8'(T_WP_CYC - 1) : 8'(T_ACC_CYC - 1);
                    strobe.we_n <= !is_wr;
                    strobe.oe_n <= is_wr;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                PH_STROBE: if (cnt_zero) begin
                    phase       <= PH_HOLD;
                    cnt         <= 8'(T_HOLD_CYC - 1);
                    strobe.we_n <= 1'b1;
                    strobe.oe_n <= 1'b1;
                    if (!is_wr) begin
                        rdata <= dq_in;
                    end
                end else begin
                    cnt <= cnt - 8'h01;
                end
                PH_HOLD: if (cnt_zero) begin
                    phase       <= PH_REC;
                    cnt         <= 8'(T_REC_CYC - 1);
                    strobe.ce_n <= 1'b1;
                    dq_oe       <= 1'b0;
                    done        <= 1'b1;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                PH_REC: if (cnt_zero) begin
                    phase <= PH_IDLE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end

    AST_ADDR_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        !strobe.we_n && $past(!strobe.we_n) |-> $stable(addr) && $stable(dq_out) && dq_oe)
        else $error("address or data moved while write strobe was low");
endmodule : fcs_cycle

// >>> core/fcs_top.sv
// Host controller that drives a byte-wide flash through its command cycles.
// Function
// RL1: Command cycles are writes, hex values.
// RL2: Flash ignores upper address bits in unlocks.
// RL3: Array reads need no preceding command.
// RL4: Reset write F0 returns flash to array.
// RL5: Autoselect is three writes then one read.
// RL6: Protect status reads 00h or 01h.
// RL7: Upper address bits pick the sector.
// RL8: Program is four writes; address then data.
// RL9: Chip erase is six fixed writes.
// RL10: Sector erase ends with sector address, 30.
// RL11: Cycles of a sequence spaced below 50 us.
// RL12: Suspend allows reads, programs and autoselect.
// RL13: Resume accepted only while suspended.
// RL14: Polling bit valid after final write.
// RL15: Program polling bit inverted until done.
// RL16: Polling same when programming during suspend.
// RL17: Protected program address reports briefly, unchanged.
// RL18: Erase polling bit reads 0 until done.
// RL19: All-protected erase reports briefly then stops.
// RL20: Take array data only from next read.
// RL21: Recheck polling bit after failure bit.
// RL22: Toggle bit inverts each read while busy.
// RL23: Toggle bit valid from final write strobe.
// RL24: Toggle stops on suspend, resumes in program.
// RL25: Flash ignores commands while busy, except suspend.
// RL26: Broken sequences return flash to array.
`timescale 1ns/1ps
module fcs_top
    import fcs_pkg::*;
#(
    parameter int GAP_LIMIT = GAP_LIMIT_CYC
) (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    output logic      [FA_W-1:0] flash_addr,
    input  wire logic [FD_W-1:0] flash_dq_in,
    output logic      [FD_W-1:0] flash_dq_out,
    output logic                 flash_dq_oe,
    output fcs_strobe_t          flash_strobe
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000, ST_SEQ = 4'b0001, ST_SWAIT = 4'b0010, ST_POLL = 4'b0011,
        ST_PWAIT = 4'b0100, ST_VER = 4'b0101, ST_VWAIT = 4'b0110,
        ST_ABORT = 4'b0111, ST_AWAIT = 4'b1000
    } fcs_state_t;

    logic            rst_s1;
    logic            rst_n_s;
    fcs_state_t      st;
    fcs_state_t      next_st;
    fcs_op_t         op;
    logic [2:0]      step;
    logic [FA_W-1:0] addr_reg;
    logic [FD_W-1:0] wdata_reg;
    logic [FD_W-1:0] rdata_reg;
    logic            done_f;
    logic            fail_f;
    logic            refused_f;
    logic            rechecked;
    logic [15:0]     gap_cnt;
    logic [FD_W-1:0] dq_sync;
    logic [FD_W-1:0] eng_rdata;
    logic            eng_idle;
    logic            eng_done;
    fcs_cyc_t        cyc_req;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1  <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_s1  <= 1'b1;
            rst_n_s <= rst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequence tables.
    function automatic logic [2:0] seq_last(input fcs_op_t o);
        case (o)
            OP_AUTOSEL, OP_PROGRAM:        seq_last = 3'h3;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: seq_last = 3'h5;
            default:                       seq_last = 3'h0;
        endcase
    endfunction : seq_last

    function automatic fcs_cyc_t seq_cyc(input fcs_op_t o, input logic [2:0] s,
                                         input logic [FA_W-1:0] a, input logic [FD_W-1:0] d);
        fcs_cyc_t c;
        c = '{write: 1'b1, addr: UNLOCK_A1, data: UNLOCK_D1};
        if (s == 3'h1 || s == 3'h4) begin
            c = '{write: 1'b1, addr: UNLOCK_A2, data: UNLOCK_D2};
        end
        case (o)
            OP_READ:       c = '{write: 1'b0, addr: a, data: 8'h00};
            OP_RESET:      c = '{write: 1'b1, addr: ADDR_ANY, data: CMD_RESET};
            OP_SUSPEND:    c = '{write: 1'b1, addr: ADDR_ANY, data: CMD_SUSPEND};
            OP_RESUME:     c = '{write: 1'b1, addr: ADDR_ANY, data: CMD_RESUME};
            OP_SECTOR_ADD: c = '{write: 1'b1, addr: a, data: CMD_SECTOR_ERASE};
            OP_AUTOSEL: begin
                if (s == 3'h2) c.data = CMD_AUTOSEL;
                if (s == 3'h3) c = '{write: 1'b0, addr: a, data: 8'h00};
            end
            OP_PROGRAM: begin
                if (s == 3'h2) c.data = CMD_PROGRAM;
                if (s == 3'h3) c = '{write: 1'b1, addr: a, data: d};
            end
            OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                if (s == 3'h2) c.data = CMD_ERASE_SETUP;
                if (s == 3'h5 && o == OP_CHIP_ERASE) c.data = CMD_CHIP_ERASE;
                if (s == 3'h5 && o == OP_SECTOR_ERASE) c = '{write: 1'b1, addr: a,
                                                             data: CMD_SECTOR_ERASE};
            end
            default: c = '{write: 1'b0, addr: a, data: 8'h00};
        endcase
        return c;
    endfunction : seq_cyc

    ////////////////////////////////////////////////////////////////////////////
    // Register decode and events.
    wire busy       = (st != ST_IDLE);
    wire sel_ctrl   = (paddr == REG_CTRL);
    wire sel_addr   = (paddr == REG_ADDR);
    wire sel_wdata  = (paddr == REG_WDATA);
    wire sel_status = (paddr == REG_STATUS);
    wire sel_rdata  = (paddr == REG_RDATA);
    wire mapped     = sel_ctrl | sel_addr | sel_wdata | sel_status | sel_rdata;
    wire setup_ph   = psel & ~penable;
    wire wr_acc     = psel & penable & pready & pwrite;
    wire op_ok      = (pwdata[3:0] <= OP_POLL);
    wire cmd_go     = wr_acc & sel_ctrl & ~busy & op_ok;
    wire wr_refused = wr_acc & ((busy & (sel_ctrl | sel_addr | sel_wdata))
                                | (sel_ctrl & ~op_ok));
    wire last_step  = (step == seq_last(op));
    wire poll_ops   = (op == OP_PROGRAM) | (op == OP_CHIP_ERASE);
    wire read_ops   = (op == OP_READ) | (op == OP_AUTOSEL);
    wire want_bit   = (op == OP_PROGRAM) ? wdata_reg[POLL_BIT] : 1'b1; // RL15 RL18
    wire poll_hit   = (eng_rdata[POLL_BIT] == want_bit);
    wire fail_seen  = eng_rdata[FAIL_BIT];
    wire seq_end    = (st == ST_SWAIT) & eng_done & last_step;
    wire give_up    = (st == ST_PWAIT) & eng_done & ~poll_hit & fail_seen & rechecked;
    wire finish     = (seq_end & ~poll_ops) | (eng_done & ((st == ST_VWAIT) | (st == ST_AWAIT)));
    wire issuing    = (st == ST_SEQ) | (st == ST_POLL) | (st == ST_VER) | (st == ST_ABORT);
    wire eng_start  = issuing & eng_idle;
    wire [31:0] rd_val = sel_ctrl   ? {28'h0000000, op} :
                         sel_addr   ? {14'h0000, addr_reg} :
                         sel_wdata  ? {24'h000000, wdata_reg} :
                         sel_status ? {28'h0000000, refused_f, fail_f, done_f, busy} :
                         sel_rdata  ? {24'h000000, rdata_reg} : 32'h00000000;

    // Polls and the final verify read always go to the stored address, so a
    // program polls its own location and a chip erase polls an erasing sector.
    assign cyc_req = (st == ST_SEQ)   ? seq_cyc(op, step, addr_reg, wdata_reg) :
                     (st == ST_ABORT) ?
                     fcs_cyc_t'{write: 1'b1, addr: ADDR_ANY, data: CMD_RESET} : // RL4
                     fcs_cyc_t'{write: 1'b0, addr: addr_reg, data: 8'h00}; // RL15 RL18

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE:  if (cmd_go) next_st = (pwdata[3:0] == OP_POLL) ? ST_POLL : ST_SEQ;
            ST_SEQ:   if (eng_idle) next_st = ST_SWAIT;
            ST_SWAIT: if (eng_done) next_st = !last_step ? ST_SEQ :
                                              poll_ops ? ST_POLL : ST_IDLE; // RL8 RL9
            ST_POLL:  if (eng_idle) next_st = ST_PWAIT;
            ST_PWAIT: if (eng_done) next_st = poll_hit ? ST_VER :
                                              (fail_seen & rechecked) ? ST_ABORT : ST_POLL; // RL21
            ST_VER:   if (eng_idle) next_st = ST_VWAIT; // RL20
            ST_VWAIT: if (eng_done) next_st = ST_IDLE;
            ST_ABORT: if (eng_idle) next_st = ST_AWAIT;
            ST_AWAIT: if (eng_done) next_st = ST_IDLE;
            default:  next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st        <= ST_IDLE;
            op        <= OP_READ;
            step      <= 3'h0;
            rechecked <= 1'b0;
        end else begin
            st <= next_st;
            if (cmd_go) begin
                op        <= fcs_op_t'(pwdata[3:0]);
                step      <= 3'h0;
                rechecked <= 1'b0;
            end else if ((st == ST_SWAIT) && eng_done && !last_step) begin
                step <= step + 3'h1;
            end else if ((st == ST_PWAIT) && eng_done && !poll_hit && fail_seen) begin
                rechecked <= 1'b1; // RL21
            end
        end
    end

    // Hardware sets these while busy, or sets refused_f from idle on a bad op code,
    // and software only clears them by starting a valid command from idle, so a set and a clear never meet.
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            done_f    <= 1'b0;
            fail_f    <= 1'b0;
            refused_f <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            done_f    <= finish | (done_f & ~cmd_go);
            fail_f    <= give_up | (fail_f & ~cmd_go);
            refused_f <= wr_refused | (refused_f & ~cmd_go);
            if ((seq_end && read_ops) || ((st == ST_VWAIT) && eng_done)) begin
                rdata_reg <= eng_rdata; // RL20
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            addr_reg  <= ADDR_RST;
            wdata_reg <= WDATA_RST;
            gap_cnt   <= 16'h0000;
        end else begin
            if (wr_acc && sel_addr && !busy) addr_reg <= pwdata[FA_W-1:0];
            if (wr_acc && sel_wdata && !busy) wdata_reg <= pwdata[FD_W-1:0];
            gap_cnt <= (st == ST_SEQ) ? gap_cnt + 16'h0001 : 16'h0000; // RL11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: answers in the first access cycle.
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            prdata  <= setup_ph ? rd_val : prdata;
            pslverr <= setup_ph & ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin cycle engine and data input synchroniser.
    fcs_sync #(.W(FD_W)) u_dq_sync (
        .clk   (clk),
        .rst_n (rst_n_s),
        .d     (flash_dq_in),
        .q     (dq_sync)
    );

    fcs_cycle u_cycle (
        .clk    (clk),
        .rst_n  (rst_n_s),
        .start  (eng_start),
        .req    (cyc_req),
        .dq_in  (dq_sync),
        .strobe (flash_strobe),
        .addr   (flash_addr),
        .dq_out (flash_dq_out),
        .dq_oe  (flash_dq_oe),
        .idle   (eng_idle),
        .done   (eng_done),
        .rdata  (eng_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_seq_start;
        (st == ST_SEQ) && eng_start;
    endsequence

    sequence s_poll_hit;
        (st == ST_PWAIT) && eng_done && poll_hit;
    endsequence

    AST_SEQ_WRITES: assert property (@(posedge clk) disable iff (!rst_n_s) // RL1
        s_seq_start and (op != OP_READ) && !((op == OP_AUTOSEL) && (step == 3'h3))
        |-> cyc_req.write)
        else $error("command cycle issued as a read");
    AST_RESET_CODE: assert property (@(posedge clk) disable iff (!rst_n_s) // RL4
        (st == ST_ABORT) && eng_start |=> (flash_dq_out == CMD_RESET) && flash_dq_oe)
        else $error("abort did not drive the reset code");
    AST_AUTOSEL_READ: assert property (@(posedge clk) disable iff (!rst_n_s) // RL5
        s_seq_start and (op == OP_AUTOSEL) && (step == 3'h3)
        |-> !cyc_req.write && (cyc_req.addr == addr_reg))
        else $error("autoselect fourth cycle is not a read at the given address");
    AST_PROG_FOUR: assert property (@(posedge clk) disable iff (!rst_n_s) // RL8
        seq_end && (op == OP_PROGRAM) |-> (step == 3'h3) ##1 (st == ST_POLL))
        else $error("program sequence not four writes followed by polling");
    AST_CHIP_SIX: assert property (@(posedge clk) disable iff (!rst_n_s) // RL9
        s_seq_start and (op == OP_CHIP_ERASE) && (step == 3'h5)
        |-> (cyc_req.addr == UNLOCK_A1) && (cyc_req.data == CMD_CHIP_ERASE))
        else $error("chip erase sixth cycle wrong");
    AST_SECTOR_LAST: assert property (@(posedge clk) disable iff (!rst_n_s) // RL10
        s_seq_start and (op == OP_SECTOR_ERASE) && (step == 3'h5)
        |-> (cyc_req.addr == addr_reg) && (cyc_req.data == CMD_SECTOR_ERASE))
        else $error("sector erase last cycle wrong");
    AST_GAP: assert property (@(posedge clk) disable iff (!rst_n_s) // RL11
        int'(gap_cnt) < GAP_LIMIT)
        else $error("pause inside a command sequence too long");
    AST_POLL_ADDR: assert property (@(posedge clk) disable iff (!rst_n_s) // RL15
        (st == ST_POLL) && eng_start |-> !cyc_req.write ##1 (flash_addr == addr_reg))
        else $error("status poll not at the stored address");
    AST_ERASE_ZERO: assert property (@(posedge clk) disable iff (!rst_n_s) // RL18
        (st == ST_PWAIT) && eng_done && (op != OP_PROGRAM) && !eng_rdata[POLL_BIT]
        && !fail_seen |=> (st == ST_POLL) && !done_f)
        else $error("erase polling ended while the polling bit was zero");
    AST_VERIFY_READ: assert property (@(posedge clk) disable iff (!rst_n_s) // RL20
        s_poll_hit |=> (st == ST_VER) && !done_f ##[1:40] (st == ST_VWAIT))
        else $error("no separate read after polling completed");
    AST_RECHECK: assert property (@(posedge clk) disable iff (!rst_n_s) // RL21
        (st == ST_PWAIT) && eng_done && !poll_hit && fail_seen && !rechecked
        |=> (st == ST_POLL) && rechecked && !fail_f)
        else $error("failure bit not followed by a recheck");
endmodule : fcs_top

// >>> test/fcs_flash_model.sv
// Behavioural byte-wide flash that answers the controller's bus cycles.
`timescale 1ns/1ps
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] DEV_CODE = 8'h5e // Arbitrary identity value.
) (
    input  wire fcs_strobe_t     strobe,
    input  wire logic [FA_W-1:0] addr,
    input  wire logic [FD_W-1:0] din,
    output logic      [FD_W-1:0] dq
);
    logic [7:0] mem [256];
    logic [7:0] rd = 8'h00, program_byte = 8'h00;
    logic [FA_W-1:0] wa;
    int step = 0, busy = 0;
    logic tog = 0, asel = 0, ers = 0;
    logic [31:0] prot = 32'h0000_0004;
    initial foreach (mem[i]) mem[i] = 8'hff;
    // Outside a read the pins show the inverse, so a stale byte never passes.
    assign dq = (!strobe.ce_n && !strobe.oe_n) ? rd : ~rd;
    always @(negedge strobe.we_n) wa = addr;
    always @(posedge strobe.we_n) if (!strobe.ce_n && busy == 0) begin
        if (din == CMD_RESET) begin
            step = 0;
            asel = 0;
        end else if (step == 3) begin
            program_byte = din;
            busy = 3;
            step = 0;
        end else if (step == 6 && (din == CMD_CHIP_ERASE || din == CMD_SECTOR_ERASE)) begin
            ers = 1;
            busy = 3;
            step = 0;
        end else if (step == 2) begin
            step = din == CMD_PROGRAM ? 3 : din == CMD_ERASE_SETUP ? 4 : 0;
            asel = din == CMD_AUTOSEL;
        end else if (step != 6 && wa[11:0] == (step[0] ? 12'h2aa : 12'h555)
                     && din == (step[0] ? 8'h55 : 8'haa)) step++;
        else step = 0;
    end
    always @(negedge strobe.oe_n) if (!strobe.ce_n) begin
        if (busy > 0) begin
            tog = ~tog;
            rd = {ers ? 1'b0 : ~program_byte[7], tog, 6'h00};
            busy--;
            if (busy == 0) begin
                foreach (mem[i]) if (ers || (i == wa[7:0] && !prot[wa[17:13]]))
                    mem[i] = ers ? 8'hff : mem[i] & program_byte;
                ers = 0;
            end
        end else rd = !asel ? mem[addr[7:0]] : addr[1:0] == 2'h1 ? DEV_CODE
                    : addr[1:0] == 2'h2 ? {7'h00, prot[addr[17:13]]} : 8'h00;
    end
endmodule : fcs_flash_model

// >>> test/fcs_tb_top.sv
// Self-checking bench for the flash command and status controller.
`timescale 1ns/1ps
module fcs_tb_top;
    import fcs_pkg::*;
    localparam logic [7:0] DEV = 8'h5e;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, foe, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic [FA_W-1:0] fa;
    logic [FD_W-1:0] fin, fout;
    fcs_strobe_t fst;
    int mismatches = 0, n_tests = 0;
    fcs_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(fa), .flash_dq_in(fin), .flash_dq_out(fout), .flash_dq_oe(foe),
        .flash_strobe(fst));
    fcs_flash_model #(.DEV_CODE(DEV)) flash (.strobe(fst), .addr(fa), .din(fout), .dq(fin));
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // The first poll may land before busy rises, so it is never trusted.
    task automatic run(input logic [3:0] op, input logic [31:0] exp_st);
        apb(1, REG_CTRL, {28'h0, op});
        for (int i = 0; i < 500; i++) begin
            apb(0, REG_STATUS, 0);
            if (i > 0 && rv[ST_BUSY] === 1'b0) break;
        end
        chk("status", rv, exp_st);
    endtask : run
    task automatic t_regs;
        apb(0, REG_WDATA, 0);
        chk("wdata", rv, 32'h0000_00ff);
        apb(0, 12'h014, 0);
        chk("unmapped", {31'h0, err}, 32'h1);
        run(4'ha, 32'h8);
    endtask : t_regs
    task automatic t_program;
        apb(1, REG_ADDR, 32'h3f012);
        apb(1, REG_WDATA, 32'h5a);
        run(4'h3, 32'h2);
        run(4'h0, 32'h2);
        apb(0, REG_RDATA, 0);
        chk("array", rv, 32'h5a);
    endtask : t_program
    task automatic t_autosel;
        apb(1, REG_ADDR, 32'h1);
        run(4'h2, 32'h2);
        apb(0, REG_RDATA, 0);
        chk("dev code", rv, {24'h0, DEV});
        apb(1, REG_ADDR, 32'h4002);
        run(4'h2, 32'h2);
        apb(0, REG_RDATA, 0);
        chk("protect", rv, 32'h1);
        run(4'h1, 32'h2);
        run(4'h0, 32'h2);
        apb(0, REG_RDATA, 0);
        chk("after reset", rv, 32'hff);
    endtask : t_autosel
    task automatic t_erase;
        apb(1, REG_ADDR, 32'h12);
        run(4'h4, 32'h2);
        run(4'h0, 32'h2);
        apb(0, REG_RDATA, 0);
        chk("erased", rv, 32'hff);
    endtask : t_erase
    task automatic t_sector;
        apb(1, REG_WDATA, 32'ha5);
        apb(1, REG_ADDR, 32'h4012);
        run(4'h3, 32'h2);
        run(4'h0, 32'h2);
        apb(0, REG_RDATA, 0);
        chk("protected", rv, 32'hff);
        apb(1, REG_ADDR, 32'h12);
        run(4'h3, 32'h2);
        for (int op = 5; op < 10; op++) begin
            run(op[3:0], 32'h2);
        end
        run(4'h0, 32'h2);
        apb(0, REG_RDATA, 0);
        chk("sector", rv, 32'hff);
    endtask : t_sector
    task automatic results;
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        #200us;
        mismatches++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_program();
        t_autosel();
        t_erase();
        t_sector();
        results();
    end
endmodule : fcs_tb_top
